// file: hw/cbm_regs.vh
`ifndef CBM_REGS_VH
`define CBM_REGS_VH

// ************************************************************
// command codes
// ************************************************************
`define CBM_OP_NOP      5'h00
`define CBM_OP_LOAD_IMM 5'h01
`define CBM_OP_IO_READ  5'h02
`define CBM_OP_IO_WRITE 5'h03
`define CBM_OP_STK_PUT  5'h04
`define CBM_OP_STK_PULL 5'h05
`define CBM_OP_MEM_OR   5'h06
`define CBM_OP_MEM_MASK 5'h07
`define CBM_OP_MEM_XOR  5'h08
`define CBM_OP_ROL      5'h09
`define CBM_OP_ROR      5'h0a
`define CBM_OP_LSL      5'h0b
`define CBM_OP_LSR      5'h0c
`define CBM_OP_ASR      5'h0d
`define CBM_OP_SWAP     5'h0e
`define CBM_OP_IO_BSET  5'h0f
`define CBM_OP_IO_BCLR  5'h10
`define CBM_OP_T_CAP    5'h11
`define CBM_OP_T_INS    5'h12
`define CBM_OP_FLAG_SET 5'h13
`define CBM_OP_FLAG_CLR 5'h14

// ************************************************************
// status flag bit positions
// ************************************************************
`define CBM_FLG_C 0
`define CBM_FLG_Z 1
`define CBM_FLG_N 2
`define CBM_FLG_V 3
`define CBM_FLG_S 4
`define CBM_FLG_H 5
`define CBM_FLG_T 6
`define CBM_FLG_I 7

// ************************************************************
// reset values and fixed indices
// ************************************************************
`define CBM_STATUS_FLAGS_REG_RST 8'h00
`define CBM_SP_RST   16'h0fff
`define CBM_Z_LO     5'd30
`define CBM_Z_HI     5'd31

// ************************************************************
// cycle counts, internal memory
// ************************************************************
`define CBM_CYC_SINGLE 1
`define CBM_CYC_PULL   2
`define CBM_CYC_RMW    2
`define CBM_CYC_EXTRA  1

`endif

// file: hw/cbm_shift_unit.v
`timescale 1ns/1ps
`include "cbm_regs.vh"

module cbm_shift_unit (
  // operation select and operands
  input  wire [4:0] op_i,
  input  wire [7:0] val_i,
  input  wire [7:0] status_flags_reg_i,
  // result and updated flags
  output reg  [7:0] res_o,
  output reg  [7:0] status_flags_reg_o
);

  // ************************************************************
  // flag helper
  // ************************************************************
  // z, n, v = n ^ c, s = n ^ v for result r and carry c
  function [7:0] zncvs;
    input [7:0] s;
    input [7:0] r;
    input       c;
    reg   [7:0] f;
    begin
      f = s;
      f[`CBM_FLG_C] = c;
      f[`CBM_FLG_Z] = (r == 8'h00);
      f[`CBM_FLG_N] = r[7];
      f[`CBM_FLG_V] = r[7] ^ c;
      f[`CBM_FLG_S] = r[7] ^ (r[7] ^ c);
      zncvs = f;
    end
  endfunction

  // ************************************************************
  // shift, rotate and swap
  // ************************************************************
  // combinational result per operation
  always @* begin
    res_o  = val_i;
    status_flags_reg_o = status_flags_reg_i;
    case (op_i)
      `CBM_OP_ROL: begin
        res_o  = {val_i[6:0], status_flags_reg_i[`CBM_FLG_C]};
        status_flags_reg_o = zncvs(status_flags_reg_i, res_o, val_i[7]);
        status_flags_reg_o[`CBM_FLG_H] = val_i[3];
      end
      `CBM_OP_ROR: begin
        res_o  = {status_flags_reg_i[`CBM_FLG_C], val_i[7:1]};
        status_flags_reg_o = zncvs(status_flags_reg_i, res_o, val_i[0]);
      end
      `CBM_OP_LSL: begin
        res_o  = {val_i[6:0], 1'b0};
        status_flags_reg_o = zncvs(status_flags_reg_i, res_o, val_i[7]);
        status_flags_reg_o[`CBM_FLG_H] = val_i[3];
      end
      `CBM_OP_LSR: begin
        res_o  = {1'b0, val_i[7:1]};
        status_flags_reg_o = zncvs(status_flags_reg_i, res_o, val_i[0]);
      end
      `CBM_OP_ASR: begin
        res_o  = {val_i[7], val_i[7:1]};
        status_flags_reg_o = zncvs(status_flags_reg_i, res_o, val_i[0]);
      end
      `CBM_OP_SWAP: begin
        res_o  = {val_i[3:0], val_i[7:4]};
      end
      default: begin
        res_o  = val_i;
        status_flags_reg_o = status_flags_reg_i;
      end
    endcase
  end

endmodule

// file: hw/cbm_exec_core.v
// Overview of operation
// - io_read and io_write move a byte register to/from I/O in one cycle.
// - stack_put writes a register to the stack in one cycle, flags kept.
// - stack_pull loads a register from the stack in two cycles, flags kept.
// - mem_fetch_or_bits returns RAM byte at Z, writes back register OR byte.
// - mem_fetch_mask_bits returns RAM byte, writes byte AND NOT register.
// - mem_fetch_xor_bits returns RAM byte, writes register XOR byte.
// - rotate_left_carry shifts up through carry, updates Z C N V H.
// - rotate_right_carry shifts down through carry, updates Z C N V.
// - io_bit_set sets one I/O register bit in one cycle.
// - io_bit_clear clears one I/O register bit in one cycle.
// - t_flag_capture copies a register bit into the transfer flag.
// - t_flag_insert copies the transfer flag into a register bit.
// - flag set commands force signed, carry, negative, zero flag to one.
// - flag clear commands force signed, carry, negative, zero, I to zero.
// - overflow flag set and clear each take one cycle.
// - half-carry flag set and clear each take one cycle.
// - memory cycle counts hold only for internal memory; external may wait.
// - flagged data-memory commands take one extra cycle on internal SRAM.
`timescale 1ns/1ps
`include "cbm_regs.vh"

module cbm_exec_core #(
  parameter [15:0] SP_RESET = `CBM_SP_RST
) (
  // clock, reset, enable
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // command port
  input  wire        cmd_valid_i,
  output wire        cmd_ready_o,
  input  wire [4:0]  cmd_op_i,
  input  wire [4:0]  cmd_reg_i,
  input  wire [5:0]  cmd_io_addr_i,
  input  wire [2:0]  cmd_bit_i,
  input  wire [7:0]  cmd_data_i,
  output reg         done_o,
  // configuration
  input  wire        sram_extra_i,
  // data memory port
  output reg  [15:0] mem_addr_o,
  output reg         mem_re_o,
  output reg         mem_we_o,
  output reg  [7:0]  mem_wdata_o,
  input  wire [7:0]  mem_rdata_i,
  input  wire        mem_ready_i,
  // i/o register space
  output wire [5:0]  io_raddr_o,
  input  wire [7:0]  io_rdata_i,
  output reg  [5:0]  io_waddr_o,
  output reg         io_we_o,
  output reg  [7:0]  io_wdata_o,
  // state views
  output wire [7:0]  status_flags_o,
  output wire [15:0] sp_o,
  input  wire [4:0]  view_reg_i,
  output reg  [7:0]  view_data_o
);

  // ************************************************************
  // states
  // ************************************************************
  // idle takes commands; wait is the sram extra cycle
  // rmw and pull wait for read data from memory
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_WAIT = 2'd1;
  localparam [1:0] S_RMW  = 2'd2;
  localparam [1:0] S_PULL = 2'd3;

  // ************************************************************
  // storage
  // ************************************************************
  // registers, flags, stack pointer, sequencer
  reg [7:0]  rf_q [0:31];
  reg [7:0]  status_flags_reg_q;
  reg [15:0] sp_q;
  reg [1:0]  st_q;
  reg [4:0]  op_q;
  reg [4:0]  reg_q;
  integer    i;

  // ************************************************************
  // command decode
  // ************************************************************
  // taken only while idle and enabled; ce_i low holds all
  wire       take     = ce_i & cmd_valid_i & (st_q == S_IDLE);
  // operands from the port while idle, latched after
  wire [4:0] op_cur   = (st_q == S_IDLE) ? cmd_op_i : op_q;
  wire [4:0] reg_cur  = (st_q == S_IDLE) ? cmd_reg_i : reg_q;
  wire [7:0] reg_val  = rf_q[reg_cur];
  // z pointer is the top register pair
  wire [15:0] z_ptr   = {rf_q[`CBM_Z_HI], rf_q[`CBM_Z_LO]};

  // one-hot mask for a bit or flag position
  function [7:0] bit_sel;
    input [2:0] pos;
    begin
      bit_sel = 8'h01 << pos;
    end
  endfunction

  wire [7:0] bit_mask = bit_sel(cmd_bit_i);

  // memory commands that start with a memory access
  function is_mem;
    input [4:0] op;
    begin
      is_mem = (op == `CBM_OP_STK_PUT) || (op == `CBM_OP_STK_PULL) ||
               (op == `CBM_OP_MEM_OR) || (op == `CBM_OP_MEM_MASK) ||
               (op == `CBM_OP_MEM_XOR);
    end
  endfunction

  // sram extra cycle applies to every memory command
  // memory access issued now: at take or after the extra cycle
  wire need_extra = take & is_mem(cmd_op_i) & sram_extra_i;
  wire issue      = (take & is_mem(cmd_op_i) & ~sram_extra_i) |
                    (ce_i & (st_q == S_WAIT));

  // ready only while idle
  // combinational, so a command may follow done
  assign cmd_ready_o    = (st_q == S_IDLE);
  assign io_raddr_o     = cmd_io_addr_i;
  assign status_flags_o = status_flags_reg_q;
  assign sp_o           = sp_q;

  // ************************************************************
  // shift unit
  // ************************************************************
  wire [7:0] sh_res;
  wire [7:0] sh_status_flags_reg;

  // fed from the port: shifts commit on the take edge
  cbm_shift_unit u_shift (
    .op_i   (cmd_op_i),
    .val_i  (reg_val),
    .status_flags_reg_i (status_flags_reg_q),
    .res_o  (sh_res),
    .status_flags_reg_o (sh_status_flags_reg)
  );

  // ************************************************************
  // read-modify-write value
  // ************************************************************
  // new ram byte from old register and old ram byte
  // mask clears the register's one bits, xor toggles
  reg [7:0] rmw_val;
  always @* begin
    case (op_q)
      `CBM_OP_MEM_OR:   rmw_val = reg_val | mem_rdata_i;
      `CBM_OP_MEM_MASK: rmw_val = ~reg_val & mem_rdata_i;
      `CBM_OP_MEM_XOR:  rmw_val = reg_val ^ mem_rdata_i;
      default:          rmw_val = mem_rdata_i;
    endcase
  end

  // flag select for set and clear commands
  wire [7:0] flag_mask = bit_sel(cmd_bit_i);

  // ************************************************************
  // sequencer and memory strobes
  // ************************************************************
  // state advance; memory waits on ready for external ram
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // back to idle with all strobes low
      st_q        <= S_IDLE;
      op_q        <= `CBM_OP_NOP;
      reg_q       <= 5'd0;
      sp_q        <= SP_RESET;
      mem_addr_o  <= 16'h0000;
      mem_re_o    <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
      done_o      <= 1'b0;
    end else if (ce_i) begin
      // write strobe and done are one-cycle pulses
      mem_we_o <= 1'b0;
      done_o   <= 1'b0;
      // latch the command; the port may change after take
      if (take) begin
        op_q  <= cmd_op_i;
        reg_q <= cmd_reg_i;
      end
      // hold one idle cycle before the access
      if (need_extra) begin
        st_q <= S_WAIT;
      end
      // start the memory access
      if (issue) begin
        case (op_cur)
          `CBM_OP_STK_PUT: begin
            // write at sp, post-decrement, done at once
            mem_addr_o  <= sp_q;
            mem_wdata_o <= reg_val;
            mem_we_o    <= 1'b1;
            sp_q        <= sp_q - 16'h0001;
            done_o      <= 1'b1;
            st_q        <= S_IDLE;
          end
          `CBM_OP_STK_PULL: begin
            // pre-increment, read the new top
            mem_addr_o <= sp_q + 16'h0001;
            mem_re_o   <= 1'b1;
            sp_q       <= sp_q + 16'h0001;
            st_q       <= S_PULL;
          end
          default: begin
            // read-modify-write reads the byte at z
            mem_addr_o <= z_ptr;
            mem_re_o   <= 1'b1;
            st_q       <= S_RMW;
          end
        endcase
      end else if (take && !need_extra) begin
        // no memory phase: done at once
        done_o <= 1'b1;
      end
      // data phase completes when memory answers
      // mem_re_o stays high through wait states
      if ((st_q == S_RMW || st_q == S_PULL) && mem_ready_i) begin
        mem_re_o <= 1'b0;
        done_o   <= 1'b1;
        st_q     <= S_IDLE;
        if (st_q == S_RMW) begin
          // write back to the read address
          mem_wdata_o <= rmw_val;
          mem_we_o    <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // register file and status flags
  // ************************************************************
  // single-cycle commands commit on the take edge
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // clear every general register
      for (i = 0; i < 32; i = i + 1) begin
        rf_q[i] <= 8'h00;
      end
      status_flags_reg_q <= `CBM_STATUS_FLAGS_REG_RST;
    end else if (ce_i) begin
      // commands without a memory phase commit here
      if (take) begin
        case (cmd_op_i)
          // immediate load for setup
          `CBM_OP_LOAD_IMM: begin
            rf_q[cmd_reg_i] <= cmd_data_i;
          end
          `CBM_OP_IO_READ: begin
            rf_q[cmd_reg_i] <= io_rdata_i;
          end
          // result and flags from the shift unit
          `CBM_OP_ROL, `CBM_OP_ROR, `CBM_OP_LSL,
          `CBM_OP_LSR, `CBM_OP_ASR, `CBM_OP_SWAP: begin
            rf_q[cmd_reg_i]    <= sh_res;
            status_flags_reg_q <= sh_status_flags_reg;
          end
          // register bit into the transfer flag
          `CBM_OP_T_CAP: begin
            status_flags_reg_q[`CBM_FLG_T] <= reg_val[cmd_bit_i];
          end
          // transfer flag into one register bit
          `CBM_OP_T_INS: begin
            rf_q[cmd_reg_i][cmd_bit_i] <= status_flags_reg_q[`CBM_FLG_T];
          end
          // set and clear cover all eight flags
          `CBM_OP_FLAG_SET: begin
            status_flags_reg_q <= status_flags_reg_q | flag_mask;
          end
          `CBM_OP_FLAG_CLR: begin
            status_flags_reg_q <= status_flags_reg_q & ~flag_mask;
          end
          default: begin
            // other commands keep the flags
            status_flags_reg_q <= status_flags_reg_q;
          end
        endcase
      end
      // old ram byte returns to the register, flags untouched
      // take needs idle, so this never meets the case above
      if ((st_q == S_RMW || st_q == S_PULL) && mem_ready_i) begin
        rf_q[reg_q] <= mem_rdata_i;
      end
    end
  end

  // ************************************************************
  // i/o write port
  // ************************************************************
  // whole-byte write and single-bit set or clear
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // no write strobe out of reset
      io_waddr_o <= 6'd0;
      io_we_o    <= 1'b0;
      io_wdata_o <= 8'h00;
    end else if (ce_i) begin
      io_we_o <= 1'b0;
      if (take) begin
        // address latched on take, used with the strobe
        io_waddr_o <= cmd_io_addr_i;
        case (cmd_op_i)
          `CBM_OP_IO_WRITE: begin
            io_wdata_o <= reg_val;
            io_we_o    <= 1'b1;
          end
          // current byte with one bit forced
          `CBM_OP_IO_BSET: begin
            io_wdata_o <= io_rdata_i | bit_mask;
            io_we_o    <= 1'b1;
          end
          `CBM_OP_IO_BCLR: begin
            io_wdata_o <= io_rdata_i & ~bit_mask;
            io_we_o    <= 1'b1;
          end
          default: begin
            // reads and other commands write nothing
            io_we_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // register view
  // ************************************************************
  // registered read-out of any general register
  // one cycle latency, held while ce_i is low
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // view reads zero after reset
      view_data_o <= 8'h00;
    end else if (ce_i) begin
      view_data_o <= rf_q[view_reg_i];
    end
  end

endmodule

// file: verification/cbm_exec_core_monitor.sv
`timescale 1ns/1ps
`include "cbm_regs.vh"

// ************************************************************
// command timing and flag checker
// ************************************************************
module cbm_exec_core_monitor (
  // clock and command side
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        cmd_valid_i,
  input wire        cmd_ready_o,
  input wire [4:0]  cmd_op_i,
  input wire [5:0]  cmd_io_addr_i,
  input wire [2:0]  cmd_bit_i,
  input wire        sram_extra_i,
  input wire        done_o,
  // memory, i/o and state
  input wire [15:0] mem_addr_o,
  input wire        mem_re_o,
  input wire        mem_we_o,
  input wire        mem_ready_i,
  input wire [5:0]  io_waddr_o,
  input wire        io_we_o,
  input wire [7:0]  status_flags_o,
  input wire [15:0] sp_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // decoded accepted commands
  wire take = ce_i & cmd_valid_i & cmd_ready_o;
  wire put  = take & (cmd_op_i == `CBM_OP_STK_PUT);
  wire pull = take & (cmd_op_i == `CBM_OP_STK_PULL);
  wire rmw  = take & (cmd_op_i >= `CBM_OP_MEM_OR) & (cmd_op_i <= `CBM_OP_MEM_XOR);
  wire one  = take & ((cmd_op_i < `CBM_OP_STK_PUT) | (cmd_op_i > `CBM_OP_MEM_XOR));
  wire iow  = take & (cmd_op_i inside {`CBM_OP_IO_WRITE, `CBM_OP_IO_BSET, `CBM_OP_IO_BCLR});
  wire keep = take & (cmd_op_i inside {`CBM_OP_NOP, `CBM_OP_IO_READ, `CBM_OP_IO_WRITE,
    `CBM_OP_STK_PUT, `CBM_OP_STK_PULL, `CBM_OP_MEM_MASK, `CBM_OP_IO_BSET,
    `CBM_OP_IO_BCLR, `CBM_OP_T_INS});
  wire fset = take & (cmd_op_i == `CBM_OP_FLAG_SET);
  wire fclr = take & (cmd_op_i == `CBM_OP_FLAG_CLR);

  a_single_done: assert property (one |=> done_o)
    else $error("single-cycle command late");
  a_put_timing: assert property (put && !sram_extra_i |=> done_o && mem_we_o
    && mem_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001)
    else $error("push timing or pointer wrong");
  a_pull_timing: assert property (pull && !sram_extra_i |=> mem_re_o && !done_o
    && sp_o == $past(sp_o) + 16'h0001 && mem_addr_o == sp_o ##1 done_o == $past(mem_ready_i))
    else $error("pop timing or pointer wrong");
  a_rmw_timing: assert property (rmw && !sram_extra_i |=> mem_re_o && !done_o
    ##1 done_o == $past(mem_ready_i))
    else $error("read-modify-write timing wrong");
  a_put_extra: assert property (put && sram_extra_i |=> !done_o ##1 done_o)
    else $error("push extra cycle wrong");
  a_read_extra: assert property ((pull || rmw) && sram_extra_i |=> !done_o [*2])
    else $error("read extra cycle missing");
  a_read_hold: assert property (mem_re_o && !mem_ready_i |=> mem_re_o && $stable(mem_addr_o))
    else $error("read dropped during wait");
  a_flags_kept: assert property (keep |=> $stable(status_flags_o))
    else $error("flags changed");
  a_flag_set: assert property (fset |=>
    status_flags_o == ($past(status_flags_o) | (8'h01 << $past(cmd_bit_i))))
    else $error("flag set wrong");
  a_flag_clr: assert property (fclr |=>
    status_flags_o == ($past(status_flags_o) & ~(8'h01 << $past(cmd_bit_i))))
    else $error("flag clear wrong");
  a_io_strobe: assert property (iow |=> io_we_o && io_waddr_o == $past(cmd_io_addr_i))
    else $error("i/o write strobe wrong");
  a_busy_ready: assert property ((pull || rmw) |=> !cmd_ready_o)
    else $error("ready high while busy");

  c_pull_extra: cover property (pull && sram_extra_i);
  c_read_wait: cover property (mem_re_o && !mem_ready_i);
  c_rmw_done: cover property (rmw ##2 done_o);
endmodule

bind cbm_exec_core cbm_exec_core_monitor u_mon (.*);

// file: verification/cbm_mem_model.sv
`timescale 1ns/1ps

// ************************************************************
// data memory and i/o space model
// ************************************************************
module cbm_mem_model (
  // clock and wait setting
  input  wire        clk_sys_i,
  input  wire [3:0]  wait_i,
  // data memory port
  input  wire [15:0] mem_addr_i,
  input  wire        mem_re_i,
  input  wire        mem_we_i,
  input  wire [7:0]  mem_wdata_i,
  output wire [7:0]  mem_rdata_o,
  output wire        mem_ready_o,
  // i/o space
  input  wire [5:0]  io_raddr_i,
  output wire [7:0]  io_rdata_o,
  input  wire [5:0]  io_waddr_i,
  input  wire        io_we_i,
  input  wire [7:0]  io_wdata_i
);
  reg [7:0] ram [0:8191];
  reg [7:0] io  [0:63];
  reg [3:0] wait_q = 4'h0;
  // zero wait acts as internal memory, more stalls like external ram
  assign mem_ready_o = (wait_q >= wait_i);
  assign mem_rdata_o = (mem_re_i && mem_ready_o) ? ram[mem_addr_i[12:0]] : ~ram[mem_addr_i[12:0]];
  assign io_rdata_o  = io[io_raddr_i];
  // stall counter and write ports
  always @(posedge clk_sys_i) begin
    wait_q <= (mem_re_i && !mem_ready_o) ? wait_q + 4'h1 : 4'h0;
    if (mem_we_i) ram[mem_addr_i[12:0]] <= mem_wdata_i;
    if (io_we_i) io[io_waddr_i] <= io_wdata_i;
  end
endmodule

// file: verification/cbm_exec_core_test.sv
`timescale 1ns/1ps
`include "cbm_regs.vh"

module cbm_exec_core_test;
  // ************************************************************
  // stimulus signals, dut and memory
  // ************************************************************
  reg         clk_sys_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cmd_valid_i = 1'b0;
  reg  [4:0]  cmd_op_i = 5'h00;
  reg  [4:0]  cmd_reg_i = 5'h00;
  reg  [5:0]  cmd_io_addr_i = 6'h00;
  reg  [2:0]  cmd_bit_i = 3'h0;
  reg  [7:0]  cmd_data_i = 8'h00;
  reg         sram_extra_i = 1'b0;
  reg         ce_i = 1'b1;
  reg  [3:0]  wait_n = 4'h0;
  reg  [4:0]  view_reg_i = 5'h00;
  wire        cmd_ready_o, done_o, mem_re_o, mem_we_o, mem_ready_i, io_we_o;
  wire [15:0] mem_addr_o, sp_o;
  wire [7:0]  mem_wdata_o, mem_rdata_i, io_rdata_i, io_wdata_o, status_flags_o, view_data_o;
  wire [5:0]  io_raddr_o, io_waddr_o;
  integer     fail_count = 0;
  integer     compares = 0;
  integer     lat;
  reg  [7:0]  v;
  always #50 clk_sys_i = ~clk_sys_i;
  cbm_exec_core DUT (.*);
  cbm_mem_model u_mem (.clk_sys_i(clk_sys_i), .wait_i(wait_n), .mem_addr_i(mem_addr_o),
    .mem_re_i(mem_re_o), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i), .mem_ready_o(mem_ready_i), .io_raddr_i(io_raddr_o),
    .io_rdata_o(io_rdata_i), .io_waddr_i(io_waddr_o), .io_we_i(io_we_o), .io_wdata_i(io_wdata_o));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(input string n, input [15:0] s, input [15:0] e);
    compares = compares + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  // issue one command, count cycles to done, settle one cycle
  task cmd(input [4:0] op, input [4:0] r, input [5:0] a, input [2:0] b, input [7:0] d);
    cmd_op_i = op;
    cmd_reg_i = r;
    cmd_io_addr_i = a;
    cmd_bit_i = b;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b0;
    lat = 1;
    while (done_o !== 1'b1 && lat < 20) begin
      @(posedge clk_sys_i);
      #1;
      lat = lat + 1;
    end
    @(posedge clk_sys_i);
    #1;
  endtask
  task ld(input [4:0] r, input [7:0] d);
    cmd(`CBM_OP_LOAD_IMM, r, 6'h00, 3'h0, d);
  endtask
  task rd(input [4:0] r);
    view_reg_i = r;
    @(posedge clk_sys_i);
    #1;
    v = view_data_o;
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_io;
    ld(5'h05, 8'ha5);
    cmd(`CBM_OP_IO_WRITE, 5'h05, 6'h10, 3'h0, 8'h00);
    chk("io write", {8'h00, u_mem.io[16]}, 16'h00a5);
    chk("io write cycles", lat[15:0], 16'h0001);
    u_mem.io[17] = 8'h3c;
    cmd(`CBM_OP_IO_READ, 5'h06, 6'h11, 3'h0, 8'h00);
    rd(5'h06);
    chk("io read", {8'h00, v}, 16'h003c);
    chk("flags after io", {8'h00, status_flags_o}, 16'h0000);
  endtask
  // every bit of an i/o byte and of the status flags, set then cleared
  task t_bits;
    integer i;
    reg [7:0] e;
    u_mem.io[32] = 8'h00;
    e = 8'h00;
    for (i = 0; i < 16; i = i + 1) begin
      e[i%8] = (i < 8);
      cmd((i < 8) ? `CBM_OP_IO_BSET : `CBM_OP_IO_BCLR, 5'h00, 6'h20, i[2:0], 8'h00);
      chk("io bit", {8'h00, u_mem.io[32]}, {8'h00, e});
      cmd((i < 8) ? `CBM_OP_FLAG_SET : `CBM_OP_FLAG_CLR, 5'h00, 6'h00, i[2:0], 8'h00);
      chk("flag bit", {8'h00, status_flags_o}, {8'h00, e});
    end
  endtask
  task t_stack;
    ld(5'h01, 8'h5a);
    cmd(`CBM_OP_STK_PUT, 5'h01, 6'h00, 3'h0, 8'h00);
    chk("push data", {8'h00, u_mem.ram[4095]}, 16'h005a);
    chk("push cycles", lat[15:0], 16'h0001);
    chk("sp after push", sp_o, 16'h0ffe);
    cmd(`CBM_OP_STK_PULL, 5'h02, 6'h00, 3'h0, 8'h00);
    chk("pop cycles", lat[15:0], 16'h0002);
    chk("sp after pop", sp_o, 16'h0fff);
    rd(5'h02);
    chk("pop data", {8'h00, v}, 16'h005a);
    sram_extra_i = 1'b1;
    cmd(`CBM_OP_STK_PUT, 5'h01, 6'h00, 3'h0, 8'h00);
    chk("push extra cycles", lat[15:0], 16'h0002);
    cmd(`CBM_OP_STK_PULL, 5'h02, 6'h00, 3'h0, 8'h00);
    chk("pop extra cycles", lat[15:0], 16'h0003);
    sram_extra_i = 1'b0;
    wait_n = 4'h3;
    cmd(`CBM_OP_STK_PULL, 5'h02, 6'h00, 3'h0, 8'h00);
    chk("pop stalled cycles", lat[15:0], 16'h0005);
    wait_n = 4'h0;
  endtask
  task t_rmw;
    integer i;
    reg [7:0] e;
    ld(5'h1e, 8'h00);
    ld(5'h1f, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
      u_mem.ram[256] = 8'hc3;
      ld(5'h04, 8'h5a);
      e = (i == 0) ? 8'hdb : (i == 1) ? 8'h81 : 8'h99;
      cmd(`CBM_OP_MEM_OR + i[4:0], 5'h04, 6'h00, 3'h0, 8'h00);
      chk("rmw cycles", lat[15:0], 16'h0002);
      chk("rmw write back", {8'h00, u_mem.ram[256]}, {8'h00, e});
      rd(5'h04);
      chk("rmw old byte", {8'h00, v}, 16'h00c3);
    end
  endtask
  task t_shift;
    integer i;
    ld(5'h07, 8'h81);
    cmd(`CBM_OP_FLAG_SET, 5'h00, 6'h00, 3'h0, 8'h00);
    cmd(`CBM_OP_ROL, 5'h07, 6'h00, 3'h0, 8'h00);
    rd(5'h07);
    chk("rotate left", {v, status_flags_o}, 16'h0319);
    cmd(`CBM_OP_ROR, 5'h07, 6'h00, 3'h0, 8'h00);
    rd(5'h07);
    chk("rotate right", {v, status_flags_o}, 16'h8115);
    for (i = 0; i < 4; i = i + 1) begin
      ld(5'h07, 8'h96);
      cmd(`CBM_OP_LSL + i[4:0], 5'h07, 6'h00, 3'h0, 8'h00);
      rd(5'h07);
      chk("shift or swap", {8'h00, v}, (i == 0) ? 16'h002c : (i == 1) ? 16'h004b :
        (i == 2) ? 16'h00cb : 16'h0069);
    end
  endtask
  task t_tbit;
    reg [7:0] f;
    ld(5'h08, 8'h10);
    ld(5'h09, 8'h00);
    f = status_flags_o;
    cmd(`CBM_OP_T_CAP, 5'h08, 6'h00, 3'h4, 8'h00);
    chk("t capture", {8'h00, status_flags_o}, {8'h00, f | 8'h40});
    cmd(`CBM_OP_T_INS, 5'h09, 6'h00, 3'h2, 8'h00);
    rd(5'h09);
    chk("t insert", {v, status_flags_o}, {8'h04, f | 8'h40});
    cmd(`CBM_OP_T_CAP, 5'h08, 6'h00, 3'h3, 8'h00);
    chk("t capture zero", {8'h00, status_flags_o}, {8'h00, f & 8'hbf});
  endtask

  // ce_i low holds a pending write; then a mid-run reset
  task t_freeze;
    ld(5'h0b, 8'h66);
    ce_i = 1'b0;
    cmd_op_i = `CBM_OP_IO_WRITE;
    cmd_reg_i = 5'h0b;
    cmd_io_addr_i = 6'h12;
    cmd_valid_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("frozen strobe", {14'h0000, io_we_o, done_o}, 16'h0000);
    ce_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b0;
    chk("resumed write", {io_wdata_o, 6'h00, io_we_o, done_o}, 16'h6603);
    rst_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    chk("sp after reset", sp_o, 16'h0fff);
    cmd(`CBM_OP_FLAG_SET, 5'h00, 6'h00, 3'h3, 8'h00);
    chk("flags after reset", {8'h00, status_flags_o}, 16'h0008);
  endtask

  // watchdog against a hung handshake
  initial begin
    #400_000;
    fail_count = fail_count + 1;
    results;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    chk("sp reset", sp_o, 16'h0fff);
    t_io;
    t_bits;
    t_stack;
    t_rmw;
    t_shift;
    t_tbit;
    t_freeze;
    results;
  end
endmodule
